// ===== iagrp_pkg.sv
package iagrp_pkg;
   localparam int unsigned IAGRP_DW = 32;
   localparam int unsigned IAGRP_AW = 12;
   localparam logic [IAGRP_AW-1:0] IAGRP_G21_SRC_OFF = 12'h104;
   localparam logic [IAGRP_AW-1:0] IAGRP_G21_EN_OFF  = 12'h108;
   localparam logic [IAGRP_AW-1:0] IAGRP_G21_RES_OFF = 12'h10c;
   localparam logic [IAGRP_AW-1:0] IAGRP_G22_SRC_OFF = 12'h118;
   localparam logic [IAGRP_AW-1:0] IAGRP_G22_EN_OFF  = 12'h11c;
   localparam logic [IAGRP_AW-1:0] IAGRP_G22_RES_OFF = 12'h120;
   localparam int unsigned IAGRP_SCRATCH_POS = 31;
   localparam int unsigned IAGRP_WAKE_POS = 17;
   localparam int unsigned IAGRP_COMP_EVTS = 15;
   localparam int unsigned IAGRP_TPM_POS = 15;
   localparam int unsigned IAGRP_BUSC_POS = 16;
   localparam logic [IAGRP_DW-1:0] IAGRP_G21_MASK = 32'h0003ffff;
   localparam logic [IAGRP_DW-1:0] IAGRP_G22_MASK = 32'h0000ffff;
   localparam logic [IAGRP_DW-1:0] IAGRP_RST_VAL  = 32'h00000000;
   typedef struct packed {
      logic                sel;
      logic                wr;
      logic [IAGRP_AW-1:0] addr;
      logic [IAGRP_DW-1:0] wdata;
   } iagrp_req_t;
   typedef struct packed {
      logic                ack;
      logic [IAGRP_DW-1:0] rdata;
   } iagrp_rsp_t;
endpackage

// ===== iagrp_group.sv
// One interrupt group: source, enable, result with scratch bit
module iagrp_group #(
   parameter logic [31:0] SRC_MASK = 32'h0000ffff,
   parameter bit          SRC_REG  = 1'b1
) (
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic [31:0] evt_i,
   input  wire logic        wr_src_i,
   input  wire logic        wr_en_i,
   input  wire logic        wr_res_i,
   input  wire logic [31:0] wdata_i,
   output logic      [31:0] src_o,
   output logic      [31:0] en_o,
   output logic      [31:0] res_o,
   output logic             irq_o
);
   import iagrp_pkg::*;
   logic [31:0] src_q, en_q;
   logic        scratch_q;
   logic [31:0] src_d, en_d, res_bits;
   // Bit 31 belongs to the scratch bit; a source there would never reach res_o, though it would still drive irq_o
   if (SRC_MASK[IAGRP_SCRATCH_POS]) begin : g_bad_mask
      $error("Bit 31 cannot carry a source");
   end
   // Set wins over write-one-to-clear; reserved bits held at zero
   assign src_d = ((src_q & ~(wr_src_i ? wdata_i : 32'h00000000)) | evt_i) & SRC_MASK;
   assign en_d  = wr_en_i ? (wdata_i & SRC_MASK) : en_q;
   assign res_bits = src_q & en_q & SRC_MASK;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         src_q  <= IAGRP_RST_VAL;
         en_q   <= IAGRP_RST_VAL;
         scratch_q <= 1'b0;
      end else begin
         src_q <= src_d;
         en_q  <= en_d;
         if (wr_res_i) scratch_q <= wdata_i[IAGRP_SCRATCH_POS];
      end
   end
   assign src_o = SRC_REG ? src_q : 32'h00000000;
   assign en_o  = en_q;
   assign res_o = {scratch_q, res_bits[30:0]};
   assign irq_o = |res_bits;
endmodule // iagrp_group

// ===== iagrp_top.sv
module iagrp_top (
   input  wire logic                  CLK_SYS_I,
   input  wire logic                  RST_N_I,
   input  wire iagrp_pkg::iagrp_req_t BUS_REQ_I,
   output iagrp_pkg::iagrp_rsp_t      BUS_RSP_O,
   input  wire logic [14:0]           COMP_EVT_I,
   input  wire logic                  TPM_IRQ_I,
   input  wire logic                  BUSC_IRQ_I,
   input  wire logic                  ATTN_I,
   input  wire logic [15:0]           PIN_EVT_I,
   output logic                       G21_IRQ_O,
   output logic                       G22_IRQ_O,
   output logic                       WAKE_O
);
   import iagrp_pkg::*;
   logic        rst_s1_q, rst_s2_q;
   logic [1:0]  attn_q;
   logic [15:0] pin_s1_q, pin_s2_q;
   logic [31:0] g21_evt, g22_evt;
   logic [31:0] g21_src, g21_en, g21_res, g22_src, g22_en, g22_res;
   logic [31:0] rd_d;
   logic        ack_q;
   logic [31:0] rdata_q;
   logic        wr, hit;
   logic        wr_g21_src, wr_g21_en, wr_g21_res;
   logic        wr_g22_src, wr_g22_en, wr_g22_res;
   always_ff @(posedge CLK_SYS_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         rst_s1_q <= 1'b0;
         rst_s2_q <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_s2_q <= rst_s1_q;
      end
   end
   // Pin events come from outside the clock domain
   always_ff @(posedge CLK_SYS_I or negedge rst_s2_q) begin
      if (!rst_s2_q) begin
         attn_q   <= 2'h0;
         pin_s1_q <= 16'h0000;
         pin_s2_q <= 16'h0000;
      end else begin
         attn_q   <= {attn_q[0], ATTN_I};
         pin_s1_q <= PIN_EVT_I;
         pin_s2_q <= pin_s1_q;
      end
   end
   assign g21_evt = {14'h0000, attn_q[1], BUSC_IRQ_I, TPM_IRQ_I, COMP_EVT_I};
   assign g22_evt = {16'h0000, pin_s2_q};
   assign wr  = BUS_REQ_I.sel && BUS_REQ_I.wr;
   assign wr_g21_src = wr && (BUS_REQ_I.addr == IAGRP_G21_SRC_OFF);
   assign wr_g21_en  = wr && (BUS_REQ_I.addr == IAGRP_G21_EN_OFF);
   assign wr_g21_res = wr && (BUS_REQ_I.addr == IAGRP_G21_RES_OFF);
   assign wr_g22_src = wr && (BUS_REQ_I.addr == IAGRP_G22_SRC_OFF);
   assign wr_g22_en  = wr && (BUS_REQ_I.addr == IAGRP_G22_EN_OFF);
   assign wr_g22_res = wr && (BUS_REQ_I.addr == IAGRP_G22_RES_OFF);
   iagrp_group #(.SRC_MASK(IAGRP_G21_MASK), .SRC_REG(1'b0)) u_g21 (
      .clk_i   (CLK_SYS_I),
      .rst_n_i (rst_s2_q),
      .evt_i   (g21_evt),
      .wr_src_i(wr_g21_src),
      .wr_en_i (wr_g21_en),
      .wr_res_i(wr_g21_res),
      .wdata_i (BUS_REQ_I.wdata),
      .src_o   (g21_src),
      .en_o    (g21_en),
      .res_o   (g21_res),
      .irq_o   (G21_IRQ_O)
   );
   iagrp_group #(.SRC_MASK(IAGRP_G22_MASK), .SRC_REG(1'b1)) u_g22 (
      .clk_i   (CLK_SYS_I),
      .rst_n_i (rst_s2_q),
      .evt_i   (g22_evt),
      .wr_src_i(wr_g22_src),
      .wr_en_i (wr_g22_en),
      .wr_res_i(wr_g22_res),
      .wdata_i (BUS_REQ_I.wdata),
      .src_o   (g22_src),
      .en_o    (g22_en),
      .res_o   (g22_res),
      .irq_o   (G22_IRQ_O)
   );
   // Companion source register is write-only here (u_g21 has no read path); its offset reads zero
   assign rd_d = (BUS_REQ_I.addr == IAGRP_G21_EN_OFF)  ? g21_en  :
                 (BUS_REQ_I.addr == IAGRP_G21_RES_OFF) ? g21_res :
                 (BUS_REQ_I.addr == IAGRP_G22_SRC_OFF) ? g22_src :
                 (BUS_REQ_I.addr == IAGRP_G22_EN_OFF)  ? g22_en  :
                 (BUS_REQ_I.addr == IAGRP_G22_RES_OFF) ? g22_res : 32'h00000000;
   assign hit = BUS_REQ_I.sel;
   always_ff @(posedge CLK_SYS_I or negedge rst_s2_q) begin
      if (!rst_s2_q) begin
         ack_q   <= 1'b0;
         rdata_q <= IAGRP_RST_VAL;
      end else begin
         ack_q   <= hit;
         rdata_q <= hit ? rd_d : rdata_q;
      end
   end
   assign BUS_RSP_O.ack   = ack_q;
   assign BUS_RSP_O.rdata = rdata_q;
   // Wake is the enabled attention result bit ORed with G22_IRQ_O; both come from clocked source flops
   assign WAKE_O = g21_res[IAGRP_WAKE_POS] | G22_IRQ_O;

   property p_result_and;
      @(posedge CLK_SYS_I) disable iff (!rst_s2_q)
      wr_g21_en && (BUS_REQ_I.wdata == 32'h00000000) |=> g21_res[30:0] == 31'h00000000;
   endproperty
   a_result_and: assert property (p_result_and) else $error("Result not source and enable");
   property p_irq;
      @(posedge CLK_SYS_I) disable iff (!rst_s2_q) G22_IRQ_O == |g22_res[30:0];
   endproperty
   a_irq: assert property (p_irq) else $error("Group output mismatch");
   property p_src31;
      @(posedge CLK_SYS_I) disable iff (!rst_s2_q) !g22_src[31] && !g21_en[31];
   endproperty
   a_src31: assert property (p_src31) else $error("Reserved bit 31 set");
   property p_latch;
      @(posedge CLK_SYS_I) disable iff (!rst_s2_q) pin_s2_q[0] |=> g22_src[0];
   endproperty
   a_latch: assert property (p_latch) else $error("Pin event not latched");
   property p_attn;
      @(posedge CLK_SYS_I) disable iff (!rst_s2_q) attn_q[1] |=> u_g21.src_q[17];
   endproperty
   a_attn: assert property (p_attn) else $error("Attention not captured");
   property p_en_wr;
      @(posedge CLK_SYS_I) disable iff (!rst_s2_q)
      wr_g21_en |=>
      g21_en == ($past(BUS_REQ_I.wdata) & IAGRP_G21_MASK);
   endproperty
   a_en_wr: assert property (p_en_wr) else $error("Enable write lost");
   property p_scratch;
      @(posedge CLK_SYS_I) disable iff (!rst_s2_q)
      wr_g22_res |=> g22_res[IAGRP_SCRATCH_POS] == $past(BUS_REQ_I.wdata[IAGRP_SCRATCH_POS]);
   endproperty
   a_scratch: assert property (p_scratch) else $error("Scratch bit not stored");
   // With no event arriving, a result write may only touch the scratch bit
   property p_ro;
      @(posedge CLK_SYS_I) disable iff (!rst_s2_q)
      wr_g22_res && (pin_s2_q == 16'h0000) |=> $stable(g22_res[30:0]);
   endproperty
   a_ro: assert property (p_ro) else $error("Result bits changed by write");
   property p_map;
      @(posedge CLK_SYS_I) disable iff (!rst_s2_q) TPM_IRQ_I |=> u_g21.src_q[15];
   endproperty
   a_map: assert property (p_map) else $error("Trusted module bit misplaced");
   // Clearing is only checked when no event lands in the same cycle, since set wins
   sequence s_g22_clr0;
      wr_g22_src && BUS_REQ_I.wdata[0] && !pin_s2_q[0];
   endsequence
   sequence s_g21_clr17;
      wr_g21_src && BUS_REQ_I.wdata[IAGRP_WAKE_POS] && !attn_q[1];
   endsequence
   sequence s_attn_armed;
      attn_q[1] && g21_en[IAGRP_WAKE_POS] && !wr_g21_en;
   endsequence
   property p_clr22;
      @(posedge CLK_SYS_I) disable iff (!rst_s2_q)
      s_g22_clr0 |=> !g22_src[0];
   endproperty
   a_clr22: assert property (p_clr22) else $error("Pin source not cleared");
   property p_clr21;
      @(posedge CLK_SYS_I) disable iff (!rst_s2_q)
      s_g21_clr17 |=> !u_g21.src_q[IAGRP_WAKE_POS];
   endproperty
   a_clr21: assert property (p_clr21) else $error("Companion source not cleared");
   property p_setwins;
      @(posedge CLK_SYS_I) disable iff (!rst_s2_q)
      wr_g22_src && pin_s2_q[0] |=> g22_src[0];
   endproperty
   a_setwins: assert property (p_setwins) else $error("Clear beat a new event");
   property p_rsv;
      @(posedge CLK_SYS_I) disable iff (!rst_s2_q)
      wr_g22_src |=> g22_src[30:16] == 15'h0000;
   endproperty
   a_rsv: assert property (p_rsv) else $error("Reserved source bit written");
   property p_en_rsv;
      @(posedge CLK_SYS_I) disable iff (!rst_s2_q)
      (g21_en[31:18] == 14'h0000) && (g22_en[31:16] == 16'h0000);
   endproperty
   a_en_rsv: assert property (p_en_rsv) else $error("Reserved enable bit set");
   property p_ack;
      @(posedge CLK_SYS_I) disable iff (!rst_s2_q)
      BUS_REQ_I.sel |=> BUS_RSP_O.ack;
   endproperty
   a_ack: assert property (p_ack) else $error("Access not acknowledged");
   property p_noack;
      @(posedge CLK_SYS_I) disable iff (!rst_s2_q)
      !BUS_REQ_I.sel |=> !BUS_RSP_O.ack;
   endproperty
   a_noack: assert property (p_noack) else $error("Acknowledge without access");
   property p_rd_hold;
      @(posedge CLK_SYS_I) disable iff (!rst_s2_q)
      !BUS_REQ_I.sel |=> $stable(BUS_RSP_O.rdata);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("Read data moved while idle");
   property p_wake;
      @(posedge CLK_SYS_I) disable iff (!rst_s2_q)
      s_attn_armed |=> WAKE_O;
   endproperty
   a_wake: assert property (p_wake) else $error("Enabled attention gave no wake");
   property p_g21_irq;
      @(posedge CLK_SYS_I) disable iff (!rst_s2_q)
      TPM_IRQ_I && g21_en[IAGRP_TPM_POS] && !wr_g21_en |=> G21_IRQ_O;
   endproperty
   a_g21_irq: assert property (p_g21_irq) else $error("Enabled source gave no output");
   property p_map2;
      @(posedge CLK_SYS_I) disable iff (!rst_s2_q)
      BUSC_IRQ_I |=> u_g21.src_q[IAGRP_BUSC_POS];
   endproperty
   a_map2: assert property (p_map2) else $error("Bus controller bit misplaced");
   property p_scr_keep;
      @(posedge CLK_SYS_I) disable iff (!rst_s2_q)
      !wr_g22_res |=> $stable(g22_res[IAGRP_SCRATCH_POS]);
   endproperty
   a_scr_keep: assert property (p_scr_keep) else $error("Scratch bit changed unasked");
   property p_g22_en_wr;
      @(posedge CLK_SYS_I) disable iff (!rst_s2_q)
      wr_g22_en |=> g22_en == ($past(BUS_REQ_I.wdata) & IAGRP_G22_MASK);
   endproperty
   a_g22_en_wr: assert property (p_g22_en_wr) else $error("Pin enable write lost");
endmodule // iagrp_top

// ===== iagrp_evt_model.sv
module iagrp_evt_model (
   input  wire logic        clk_i,
   input  wire logic [17:0] fire_i,
   output logic      [14:0] comp_evt_o,
   output logic             tpm_irq_o,
   output logic             busc_irq_o,
   output logic             attn_o
);
   timeunit 1ns;
   timeprecision 1ns;
   // Rising-edge update keeps each pulse one full cycle, clear of the bench's falling-edge writes
   always @(posedge clk_i) {attn_o, busc_irq_o, tpm_irq_o, comp_evt_o} <= fire_i;
endmodule // iagrp_evt_model

// ===== test_interrupt_aggregator_groups.sv
module test_interrupt_aggregator_groups
   import iagrp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk, rst_n, g21, g22, wake, tpm, busc, attn;
   logic [15:0] pin, pv;
   logic [17:0] fire, fv;
   logic [14:0] comp;
   iagrp_req_t  req;
   iagrp_rsp_t  rsp;
   logic [32:0] exp_q[$];
   logic [31:0] en21, en22;
   int          bad_count, compares, cyc, seed;

   iagrp_top DUT (.CLK_SYS_I(clk), .RST_N_I(rst_n), .BUS_REQ_I(req), .BUS_RSP_O(rsp),
      .COMP_EVT_I(comp), .TPM_IRQ_I(tpm), .BUSC_IRQ_I(busc), .ATTN_I(attn),
      .PIN_EVT_I(pin), .G21_IRQ_O(g21), .G22_IRQ_O(g22), .WAKE_O(wake));
   iagrp_evt_model u_evt (.clk_i(clk), .fire_i(fire), .comp_evt_o(comp),
      .tpm_irq_o(tpm), .busc_irq_o(busc), .attn_o(attn));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   task automatic give_verdict;
      if (exp_q.size() != 0) bad_count++;
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
      compares++;
      if (g !== e) begin
         bad_count++;
         $display("wrong value %s exp %h got %h", n, e, g);
      end
   endtask

   // One access per strobe; the read expectation waits in the queue for its ack
   task automatic acc(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(negedge clk);
      req = '{1'b1, w, a, d};
      exp_q.push_back({~w, d});
      @(negedge clk);
      req.sel = 1'b0;
   endtask

   always @(negedge clk) begin
      logic [32:0] it;
      if (rsp.ack === 1'b1 && exp_q.size() > 0) begin
         it = exp_q.pop_front();
         if (it[32]) cmp("rdata", it[31:0], rsp.rdata);
      end
   end

   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         bad_count++;
         give_verdict();
      end
   end

   initial begin
      {rst_n, pin, fire, bad_count, compares, cyc} = '0;
      req = '0;
      seed = 56075;
      repeat (16) @(negedge clk);
      rst_n = 1'b1;
      repeat (3) @(negedge clk);
      acc(0, IAGRP_G21_RES_OFF, IAGRP_RST_VAL);
      acc(0, IAGRP_G22_SRC_OFF, IAGRP_RST_VAL);
      acc(0, IAGRP_G22_EN_OFF, IAGRP_RST_VAL);
      acc(0, IAGRP_G22_RES_OFF, IAGRP_RST_VAL);
      en21 = $random(seed);
      en22 = $random(seed);
      acc(1, IAGRP_G21_EN_OFF, en21);
      acc(0, IAGRP_G21_EN_OFF, en21 & IAGRP_G21_MASK);
      acc(1, IAGRP_G22_EN_OFF, en22);
      acc(0, IAGRP_G22_EN_OFF, en22 & IAGRP_G22_MASK);
      acc(1, IAGRP_G21_RES_OFF, 32'hffffffff);
      acc(0, IAGRP_G21_RES_OFF, 32'h80000000);
      acc(1, IAGRP_G22_RES_OFF, 32'h7fffffff);
      acc(0, IAGRP_G22_RES_OFF, 32'h00000000);
      pv = $random(seed);
      pin = pv;
      repeat (4) @(negedge clk);
      pin = '0;
      repeat (3) @(negedge clk);
      acc(0, IAGRP_G22_SRC_OFF, {16'h0, pv});
      acc(0, IAGRP_G22_RES_OFF, {16'h0, pv} & en22);
      cmp("g22", {31'h0, |(pv & en22[15:0])}, {31'h0, g22});
      acc(1, IAGRP_G22_SRC_OFF, 32'hffffffff);
      acc(0, IAGRP_G22_SRC_OFF, 32'h00000000);
      @(negedge clk);
      cmp("wake", 32'h0, {31'h0, wake});
      acc(1, IAGRP_G21_EN_OFF, 32'hffffffff);
      fv = 18'($random(seed)) | 18'h20000;
      fire = fv;
      @(negedge clk);
      fire = '0;
      repeat (4) @(negedge clk);
      acc(0, IAGRP_G21_RES_OFF, {14'h2000, fv});
      cmp("wake", 32'h1, {31'h0, wake});
      cmp("g21", 32'h1, {31'h0, g21});
      acc(1, IAGRP_G21_SRC_OFF, 32'hffffffff);
      acc(0, IAGRP_G21_RES_OFF, 32'h80000000);
      cmp("wake", 32'h0, {31'h0, wake});
      pin = 16'h8001;
      repeat (3) @(negedge clk);
      acc(1, IAGRP_G22_SRC_OFF, 32'hffffffff);
      acc(0, IAGRP_G22_SRC_OFF, 32'h00008001);
      pin = '0;
      acc(0, IAGRP_G21_SRC_OFF, 32'h0);
      acc(0, 12'h200, 32'h0);
      repeat (3) @(negedge clk);
      give_verdict();
   end
endmodule // test_interrupt_aggregator_groups
